// *** hw/can_wake_and_fault_monitor.sv ***
// Wake-pattern detector and local fault monitor of a CAN transceiver.
// Assumes pin inputs are asynchronous; all but wake_clear_in are synchronised here.
`default_nettype none
`include "can_monitor_map.svh"
module can_wake_and_fault_monitor
	import can_monitor_pkg::*;
(
	input  wire logic clk_sys_in,
	input  wire logic nrst_in,
	input  wire logic clk_en_in,
	input  wire logic txd_in,
	input  wire logic rxd_pin_in,
	input  wire logic bus_dominant_in,
	input  wire logic low_power_in,
	input  wire logic local_wake_in,
	input  wire logic normal_entry_in,
	input  wire logic wake_clear_in,
	input  wire logic power_on_flag_in,
	input  wire logic supply_undervoltage_lockout_in,
	input  wire logic overtemp_in,
	output logic      bus_tx_dominant_out,
	output logic      wake_flag_out,
	output logic      remote_wake_out,
	output logic      local_failure_out,
	output logic      bus_dom_fault_out,
	output logic      tx_enable_out,
	output logic      shutdown_out
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int N_SYNC = 9;
	localparam logic [N_SYNC-1:0] IDLE_LEVEL = `SYNC_IDLE;
	logic [N_SYNC-1:0] raw;
	logic [N_SYNC-1:0] sync1;
	logic [N_SYNC-1:0] sync2;
	assign raw = {txd_in, rxd_pin_in, bus_dominant_in, low_power_in,
		local_wake_in, normal_entry_in, power_on_flag_in,
		supply_undervoltage_lockout_in, overtemp_in};

	// Two flops per pin; first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys_in or negedge nrst_in)
			begin
				// Idle levels, so no false dominant follows reset
				if (!nrst_in)
				begin
					sync1[gi] <= IDLE_LEVEL[gi];
					sync2[gi] <= IDLE_LEVEL[gi];
				end
				else if (clk_en_in)
				begin
					sync1[gi] <= raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	logic txd_s, rxd_s, bus_dom_s, low_pwr_s, lwake_s;
	logic normal_s, pwon_s, supply_undervoltage_lockout_s, otp_s;
	assign {txd_s, rxd_s, bus_dom_s, low_pwr_s, lwake_s,
		normal_s, pwon_s, supply_undervoltage_lockout_s, otp_s} = sync2;

	// ****************************************
	// Wake-pattern detector
	// ****************************************
	wake_state_t         wk_state, next_wk_state;
	logic [`CNT_W-1:0]   phase_cnt, next_phase_cnt;
	logic [`CNT_W-1:0]   win_cnt, next_win_cnt;
	logic                bus_dom_d, next_bus_dom_d;
	logic                remote_hit;

	// Phase counter restarts on each bus level change
	always_comb
	begin
		next_wk_state  = wk_state;
		next_bus_dom_d = bus_dom_s;
		remote_hit     = 1'b0;
		if (bus_dom_s != bus_dom_d)
			next_phase_cnt = `CNT_ZERO;
		else if (phase_cnt != {`CNT_W{1'b1}})
			next_phase_cnt = phase_cnt + `CNT_ONE;
		else
			next_phase_cnt = phase_cnt;
		next_win_cnt = (wk_state == wk_idle) ? `CNT_ZERO :
			win_cnt + `CNT_ONE;
		case (wk_state)
			wk_idle:
				if (low_pwr_s && bus_dom_s)
					next_wk_state = wk_dom1;
			wk_dom1:
				if (!bus_dom_s)
					next_wk_state = (phase_cnt >= `CNT_W'(`WAKE_DOM_CYC - 1))
						? wk_rec : wk_idle;
			wk_rec:
				if (bus_dom_s)
					next_wk_state = (phase_cnt >= `CNT_W'(`WAKE_REC_CYC - 1))
						? wk_dom2 : wk_dom1;
			wk_dom2:
				if (!bus_dom_s)
					next_wk_state = wk_idle;
				else if (phase_cnt >= `CNT_W'(`WAKE_DOM_CYC - 1))
				begin
					remote_hit    = 1'b1;
					next_wk_state = wk_idle;
				end
			default:
				next_wk_state = wk_idle;
		endcase
		// Window expiry or leaving low power restarts the detector
		if (!low_pwr_s ||
			(wk_state != wk_idle && win_cnt >= `CNT_W'(`WAKE_WIN_CYC - 1)))
		begin
			next_wk_state = wk_idle;
			remote_hit    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wk_state  <= wk_idle;
			phase_cnt <= `CNT_ZERO;
			win_cnt   <= `CNT_ZERO;
			bus_dom_d <= 1'b0;
		end
		else if (clk_en_in)
		begin
			wk_state  <= next_wk_state;
			phase_cnt <= next_phase_cnt;
			win_cnt   <= next_win_cnt;
			bus_dom_d <= next_bus_dom_d;
		end
	end

	// ****************************************
	// Dominant time-outs and fault flags
	// ****************************************
	logic [`CNT_W-1:0] tx_cnt, next_tx_cnt;
	logic [`CNT_W-1:0] bd_cnt, next_bd_cnt;
	logic next_wake, next_rwake, next_lfail, next_bdf, next_shut;
	logic next_txen, next_txdom;
	logic tx_to, short_ev, bd_to;

	// Counters run only while the watched level is dominant
	always_comb
	begin
		next_tx_cnt = txd_s ? `CNT_ZERO : tx_cnt;
		if (!txd_s && tx_cnt != `CNT_W'(`TX_DOM_CYC))
			next_tx_cnt = tx_cnt + `CNT_ONE;
		next_bd_cnt = bus_dom_s ? bd_cnt : `CNT_ZERO;
		if (bus_dom_s && bd_cnt != `CNT_W'(`BUS_DOM_CYC))
			next_bd_cnt = bd_cnt + `CNT_ONE;
		tx_to    = (tx_cnt == `CNT_W'(`TX_DOM_CYC));
		bd_to    = (bd_cnt == `CNT_W'(`BUS_DOM_CYC));
		// A short shows as rxd following txd low while the bus is idle
		short_ev = !txd_s && !rxd_s && !bus_dom_s && tx_enable_out;
		// Set beats clear so a coincident event is kept
		next_lfail = local_failure_out;
		if (normal_s || (!rxd_s && txd_s) || pwon_s)
			next_lfail = 1'b0;
		if (tx_to || short_ev || bd_to || otp_s)
			next_lfail = 1'b1;
		next_bdf   = bd_to && bus_dom_s;
		next_rwake = remote_hit;
		next_wake  = wake_flag_out;
		if (normal_s || wake_clear_in)
			next_wake = 1'b0;
		if (remote_hit || lwake_s)
			next_wake = 1'b1;
		next_shut  = supply_undervoltage_lockout_s || otp_s;
		next_txen  = !next_lfail && !next_shut;
		next_txdom = next_txen && !txd_s;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tx_cnt              <= `CNT_ZERO;
			bd_cnt              <= `CNT_ZERO;
			local_failure_out   <= 1'b0;
			bus_dom_fault_out   <= 1'b0;
			remote_wake_out     <= 1'b0;
			wake_flag_out       <= 1'b0;
			shutdown_out        <= 1'b0;
			tx_enable_out       <= 1'b0;
			bus_tx_dominant_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			tx_cnt              <= next_tx_cnt;
			bd_cnt              <= next_bd_cnt;
			local_failure_out   <= next_lfail;
			bus_dom_fault_out   <= next_bdf;
			remote_wake_out     <= next_rwake;
			wake_flag_out       <= next_wake;
			shutdown_out        <= next_shut;
			tx_enable_out       <= next_txen;
			bus_tx_dominant_out <= next_txdom;
		end
	end

endmodule
`default_nettype wire

// *** hw/can_monitor_map.svh ***
// Constants for the CAN wake-up and fault monitor.
// Assumes a 20 MHz system clock; times are in microseconds.
`ifndef CAN_MONITOR_MAP_SVH
`define CAN_MONITOR_MAP_SVH
`define CLK_MHZ            20
`define WAKE_DOM_MIN_US    5
`define WAKE_REC_MIN_US    5
`define WAKE_WINDOW_US     1000
`define TX_DOM_TIMEOUT_US  2000
`define BUS_DOM_TIMEOUT_US 2000
`define WAKE_DOM_CYC   (`WAKE_DOM_MIN_US * `CLK_MHZ)
`define WAKE_REC_CYC   (`WAKE_REC_MIN_US * `CLK_MHZ)
`define WAKE_WIN_CYC   (`WAKE_WINDOW_US * `CLK_MHZ)
`define TX_DOM_CYC     (`TX_DOM_TIMEOUT_US * `CLK_MHZ)
`define BUS_DOM_CYC    (`BUS_DOM_TIMEOUT_US * `CLK_MHZ)
`define CNT_W          16
`define CNT_ZERO       16'h0000
`define CNT_ONE        16'h0001
// Synchroniser reset levels: transmit and receive pins idle high
`define SYNC_IDLE      9'h180
`endif

// *** hw/can_monitor_pkg.sv ***
// Types for the CAN wake-up and fault monitor.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package can_monitor_pkg;
	typedef enum logic [2:0] {
		wk_idle,
		wk_dom1,
		wk_rec,
		wk_dom2
	} wake_state_t;
endpackage
`default_nettype wire

// *** testbench/can_monitor_properties.sv ***
// Checker for the CAN wake and fault monitor ports.
// Assumes bind to the monitor with clk_en_in held high.
`default_nettype none
module can_monitor_properties (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic low_power_in,
	input wire logic bus_dominant_in,
	input wire logic bus_tx_dominant_out,
	input wire logic wake_flag_out,
	input wire logic remote_wake_out,
	input wire logic local_failure_out,
	input wire logic bus_dom_fault_out,
	input wire logic tx_enable_out,
	input wire logic shutdown_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************
	// Properties
	// ************
	// Outputs lag pins by 3 edges: 2 sync flops and 1 register
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	a_wake_pulse_once: assert property (
		remote_wake_out |=> !remote_wake_out) else $error("long wake");
	a_wake_last_dom: assert property (
		remote_wake_out |-> $past(bus_dominant_in, 3)) else $error("wake");
	a_wake_armed: assert property (
		remote_wake_out |-> $past(low_power_in, 3)) else $error("armed");
	a_wake_flag_set: assert property (
		remote_wake_out |-> wake_flag_out) else $error("wake flag");
	a_bus_fault_cause: assert property (
		$rose(bus_dom_fault_out) |-> $past(bus_dominant_in, 3))
		else $error("bus fault");
	a_bus_fault_drop: assert property (
		!bus_dominant_in [*4] |-> !bus_dom_fault_out) else $error("drop");
	a_fault_sets_fail: assert property (
		$rose(bus_dom_fault_out) |-> ##[0:2] local_failure_out)
		else $error("failure flag");
	a_tx_off_quiet: assert property (
		!tx_enable_out [*2] |-> !bus_tx_dominant_out) else $error("tx");
	a_shut_tx_off: assert property (
		shutdown_out [*2] |-> !tx_enable_out) else $error("shutdown");
endmodule
bind can_wake_and_fault_monitor can_monitor_properties u_props (
	.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
	.low_power_in(low_power_in), .bus_dominant_in(bus_dominant_in),
	.bus_tx_dominant_out(bus_tx_dominant_out),
	.wake_flag_out(wake_flag_out), .remote_wake_out(remote_wake_out),
	.local_failure_out(local_failure_out),
	.bus_dom_fault_out(bus_dom_fault_out),
	.tx_enable_out(tx_enable_out), .shutdown_out(shutdown_out));
`default_nettype wire

// *** testbench/can_ctrl_model.sv ***
// Transmit side of the host CAN controller, behavioural.
// Assumes dominant requests come from the bench between edges.
`default_nettype none
module can_ctrl_model (
	input  wire logic clk_in,
	input  wire logic dom_req_in,
	output var  logic txd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Launch after the edge; idle is recessive high
	initial
	begin
		txd_out = 1'b1;
		forever
			@(posedge clk_in) txd_out <= !dom_req_in;
	end
endmodule
`default_nettype wire

// *** testbench/test_can_wake_and_fault_monitor.sv ***
// Self-checking bench for the CAN wake and fault monitor.
// Assumes the controller model drives the transmit pin.
`default_nettype none
module test_can_wake_and_fault_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, rxd = 1, bus = 0, lp = 1, lw = 0, ne = 0;
	logic wclr = 0, pwon = 0, uv = 0, ot = 0, dreq = 0;
	logic txd, btx, wflag, rwake, lfail, bdf, txen, shut;
	int failures = 0, checked = 0, pulses = 0, base = 0;
	// Rows: low power, dominant, recessive, dominant, wake expected
	int rows[5][5] = '{'{1, 120, 120, 120, 1}, '{1, 60, 120, 120, 0},
		'{1, 120, 60, 120, 0}, '{1, 120, 20100, 120, 0},
		'{0, 120, 120, 120, 0}};
	always #25 clk = ~clk;
	// Count wake pulses at falling edges, where the output has settled
	always @(negedge clk)
		if (rwake === 1'b1)
			pulses++;
	can_ctrl_model host (.clk_in(clk), .dom_req_in(dreq), .txd_out(txd));
	can_wake_and_fault_monitor dut (.clk_sys_in(clk), .nrst_in(nrst),
		.clk_en_in(1'b1), .txd_in(txd), .rxd_pin_in(rxd),
		.bus_dominant_in(bus), .low_power_in(lp), .local_wake_in(lw),
		.normal_entry_in(ne), .wake_clear_in(wclr),
		.power_on_flag_in(pwon), .supply_undervoltage_lockout_in(uv),
		.overtemp_in(ot), .bus_tx_dominant_out(btx), .wake_flag_out(wflag),
		.remote_wake_out(rwake), .local_failure_out(lfail),
		.bus_dom_fault_out(bdf), .tx_enable_out(txen), .shutdown_out(shut));
	task chk(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task test_done;
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// A fresh detector for every row avoids leftover pattern state
	task rst;
		nrst = 0;
		cyc(5);
		chk(lfail | txen | wflag, 1'b0);
		nrst = 1;
		cyc(5);
	endtask
	// Watchdog: the run is about 62000 cycles, this is well above it
	initial
	begin
		#4500000;
		failures++;
		test_done();
	end
	initial
	begin
		foreach (rows[i])
		begin
			lp = rows[i][0][0];
			rst();
			base = pulses;
			bus = 1;
			cyc(rows[i][1]);
			bus = 0;
			cyc(rows[i][2]);
			bus = 1;
			cyc(rows[i][3]);
			bus = 0;
			cyc(10);
			chk(pulses - base == rows[i][4], 1'b1);
			chk(wflag, rows[i][4][0]);
		end
		lw = 1;
		cyc(5);
		chk(wflag, 1'b1);
		lw = 0;
		cyc(3);
		wclr = 1;
		cyc(1);
		wclr = 0;
		chk(wflag, 1'b0);
		// Bus timeout trails the transmit one, so each shows on its own
		lp = 0;
		dreq = 1;
		cyc(20);
		chk(btx, 1'b1);
		bus = 1;
		cyc(39990);
		chk(lfail, 1'b1);
		chk(txen, 1'b0);
		chk(bdf, 1'b0);
		chk(btx, 1'b0);
		cyc(20);
		chk(bdf, 1'b1);
		bus = 0;
		cyc(3);
		chk(bdf, 1'b0);
		dreq = 0;
		cyc(5);
		chk(txen, 1'b0);
		rxd = 0;
		cyc(5);
		rxd = 1;
		cyc(5);
		chk(lfail, 1'b0);
		chk(txen, 1'b1);
		dreq = 1;
		rxd = 0;
		cyc(5);
		chk(lfail, 1'b1);
		chk(txen, 1'b0);
		dreq = 0;
		rxd = 1;
		ne = 1;
		cyc(5);
		ne = 0;
		chk(lfail, 1'b0);
		ot = 1;
		cyc(5);
		chk(shut & lfail, 1'b1);
		chk(txen, 1'b0);
		ot = 0;
		pwon = 1;
		cyc(5);
		pwon = 0;
		chk(shut | lfail, 1'b0);
		uv = 1;
		cyc(5);
		chk(shut, 1'b1);
		chk(txen, 1'b0);
		uv = 0;
		cyc(5);
		chk(shut, 1'b0);
		chk(txen, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
